// [src/ccpl_top.sv]
`timescale 1ns/1ps
`include "ccpl_regs.svh"
// Function
// - restart low restarts config, resets scan
// - pin low in config tristates all I/O
// - option keeps tristate role after config
// - falling edge starts readback at frame 0
// - serial output: readback data or scan data
// - init error drives error output low
// - host port uses same pin for irq
// - other pins release with done or after it, per option
// - PLL clock pins tristate, pulled up in config and on restart
// - done released high; external low delays start
// - readback synchronous with config clock
module ccpl_top (
	// clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// pins
	input wire logic config_restart_n_i,
	input wire logic rd_cfg_n_i,
	input wire logic config_clock_i,
	input wire logic done_pin_i,
	input wire logic scan_tdo_i,
	input wire logic scan_active_i,
	// configuration engine
	input wire logic config_busy_i,
	input wire logic config_loaded_i,
	input wire logic init_error_i,
	input wire logic host_port_used_i,
	input wire logic host_port_irq_i,
	input wire ccpl_pkg::ccpl_opt_type opt_i,
	input wire logic rb_data_i,
	// outputs
	output ccpl_pkg::ccpl_pin_type done_o,
	output logic rd_data_o,
	output logic cfg_irq_n_o,
	output logic tristate_all_o,
	output logic config_restart_o,
	output logic scan_reset_o,
	output logic pll_pins_hiz_o,
	output logic pll_pullup_o,
	output logic pins_released_o,
	output logic user_io_active_o,
	output logic startup_o,
	output logic [`CCPL_FA_W-1:0] rb_frame_o,
	output logic [15:0] rb_bit_o,
	output logic rb_active_o
);
	import ccpl_pkg::*;
	ccpl_rb_type state, next_state;
	logic rd_cfg_q; // previous readback pin level
	logic config_clock_q; // previous config clock level
	logic [`CCPL_FA_W-1:0] next_frame;
	logic [15:0] next_bit;
	logic done_rel; // done release tracked
	// decoding of pin events
	wire rd_fall = rd_cfg_q & ~rd_cfg_n_i;
	wire config_clock_rise = ~config_clock_q & config_clock_i;
	wire restart = ~config_restart_n_i;
	// readback only once loaded, enabled, and not held in tristate role
	wire rb_mode = config_loaded_i & opt_i.readback_en & ~opt_i.keep_tristate;
	wire ts_req = ~rd_cfg_n_i & (config_busy_i |
		(config_loaded_i & opt_i.keep_tristate));
	wire last_bit = (rb_bit_o == `CCPL_FRAME_BITS - 16'h0001);
	wire last_frame = (rb_frame_o == {`CCPL_FA_W{1'b1}});
	// done release then pins release; timing options pick the lag
	wire done_go = config_loaded_i & (opt_i.done_timing == `CCPL_DONE_AT_END
		| done_rel);
	wire pins_go = done_go & (opt_i.pins_timing == 2'h0 | done_o.out);
	// readback sequencer next state
	always_comb begin
		next_state = state;
		next_frame = rb_frame_o;
		next_bit = rb_bit_o;
		unique case (state)
			ccpl_rb_idle: begin
				if (rb_mode & rd_fall) begin
					next_state = ccpl_rb_wait;
					next_frame = `CCPL_FA_FIRST;
					next_bit = 16'h0000;
				end
			end
			ccpl_rb_wait: begin
				// the first bit waits for a config clock edge
				if (config_clock_rise) next_state = ccpl_rb_shift;
			end
			ccpl_rb_shift: begin
				if (config_clock_rise) begin
					if (last_bit) begin
						next_bit = 16'h0000;
						if (last_frame) next_state = ccpl_rb_idle;
						else next_frame = rb_frame_o + 8'h01;
					end else next_bit = rb_bit_o + 16'h0001;
				end
			end
			default: next_state = ccpl_rb_idle;
		endcase
		if (restart | ~rb_mode) next_state = ccpl_rb_idle;
	end
	// sequencer and edge history
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			state <= ccpl_rb_idle;
			rb_frame_o <= 8'h00;
			rb_bit_o <= 16'h0000;
			rd_cfg_q <= 1'b1;
			config_clock_q <= 1'b0;
		end else begin
			state <= next_state;
			rb_frame_o <= next_frame;
			rb_bit_o <= next_bit;
			rd_cfg_q <= rd_cfg_n_i;
			config_clock_q <= config_clock_i;
		end
	end
	// pin outputs, all registered
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			done_o <= '{out: 1'b0, oe_n: 1'b0};
			done_rel <= 1'b0;
			rd_data_o <= 1'b0;
			cfg_irq_n_o <= 1'b1;
			tristate_all_o <= 1'b0;
			config_restart_o <= 1'b0;
			scan_reset_o <= 1'b0;
			pll_pins_hiz_o <= 1'b1;
			pll_pullup_o <= 1'b1;
			pins_released_o <= 1'b0;
			user_io_active_o <= 1'b0;
			startup_o <= 1'b0;
			rb_active_o <= 1'b0;
		end else begin
			config_restart_o <= restart;
			scan_reset_o <= restart;
			tristate_all_o <= ts_req;
			// scan data wins when boundary-scan is active
			rd_data_o <= scan_active_i ? scan_tdo_i : rb_data_i;
			// host port irq shares the error pin
			cfg_irq_n_o <= host_port_used_i ? ~host_port_irq_i
				: ~(config_busy_i & init_error_i);
			pll_pins_hiz_o <= config_busy_i | restart;
			pll_pullup_o <= config_busy_i | restart;
			done_rel <= restart ? 1'b0 : config_loaded_i;
			// open drain: drive low until done, then release high
			done_o.out <= done_go & ~restart;
			done_o.oe_n <= done_go & ~restart;
			pins_released_o <= pins_go & ~restart;
			user_io_active_o <= pins_go & ~restart;
			// an external low on done holds start-up off
			startup_o <= done_go & done_pin_i & ~restart;
			rb_active_o <= (next_state != ccpl_rb_idle);
		end
	end
	// checks
	restart_scan_a: assert property (
		@(posedge clk_i) disable iff (sys_rst_i)
		!config_restart_n_i |=> scan_reset_o && config_restart_o)
		else $error("restart did not reset scan");
	// a restart also drops any readback in flight
	rb_abort_a: assert property (
		@(posedge clk_i) disable iff (sys_rst_i)
		!config_restart_n_i |=> !rb_active_o)
		else $error("readback survived restart");
	ts_cfg_a: assert property (
		@(posedge clk_i) disable iff (sys_rst_i)
		(config_busy_i && !rd_cfg_n_i) |=> tristate_all_o)
		else $error("tristate not raised in config");
	ts_opt_a: assert property (
		@(posedge clk_i) disable iff (sys_rst_i)
		(!config_busy_i && config_loaded_i && !opt_i.keep_tristate)
		|=> !tristate_all_o)
		else $error("tristate active without option");
	rb_start_a: assert property (
		@(posedge clk_i) disable iff (sys_rst_i)
		(state == ccpl_rb_idle && rb_mode && rd_fall && config_restart_n_i)
		|=> rb_frame_o == 8'h00 && rb_bit_o == 16'h0000 && rb_active_o)
		else $error("readback start wrong");
	rd_mux_a: assert property (
		@(posedge clk_i) disable iff (sys_rst_i)
		scan_active_i |=> rd_data_o == $past(scan_tdo_i))
		else $error("scan data not on output");
	// with scan idle the serial pin carries readback data
	rd_data_a: assert property (
		@(posedge clk_i) disable iff (sys_rst_i)
		!scan_active_i |=> rd_data_o == $past(rb_data_i))
		else $error("readback data not on output");
	err_out_a: assert property (
		@(posedge clk_i) disable iff (sys_rst_i)
		(!host_port_used_i && config_busy_i && init_error_i)
		|=> !cfg_irq_n_o)
		else $error("error output not low");
	irq_out_a: assert property (
		@(posedge clk_i) disable iff (sys_rst_i)
		(host_port_used_i && host_port_irq_i) |=> !cfg_irq_n_o)
		else $error("host irq not low");
	pll_hiz_a: assert property (
		@(posedge clk_i) disable iff (sys_rst_i)
		config_busy_i |=> pll_pins_hiz_o && pll_pullup_o)
		else $error("pll pins not tristated");
	start_hold_a: assert property (
		@(posedge clk_i) disable iff (sys_rst_i)
		!done_pin_i |=> !startup_o)
		else $error("start-up not delayed");
	pins_order_a: assert property (
		@(posedge clk_i) disable iff (sys_rst_i)
		(pins_released_o && opt_i.pins_timing != 2'h0 &&
		$stable(opt_i)) |-> $past(done_o.out))
		else $error("pins released before done");
	// done is let go at load when its option asks for no lag
	done_rel_a: assert property (
		@(posedge clk_i) disable iff (sys_rst_i)
		(config_loaded_i && config_restart_n_i
		&& opt_i.done_timing == `CCPL_DONE_AT_END)
		|=> done_o.out && done_o.oe_n)
		else $error("done not released at load");
	shift_step_a: assert property (
		@(posedge clk_i) disable iff (sys_rst_i)
		(state == ccpl_rb_shift && !config_clock_rise) |=> $stable(rb_bit_o))
		else $error("bit advanced without config clock");
	// frame address climbs by one after the last bit of a frame
	frame_step_a: assert property (
		@(posedge clk_i) disable iff (sys_rst_i)
		(state == ccpl_rb_shift && config_clock_rise && last_bit && !last_frame
		&& rb_mode && config_restart_n_i)
		|=> rb_frame_o == $past(rb_frame_o) + 8'h01)
		else $error("frame address did not advance");
endmodule

// [src/ccpl_regs.svh]
`ifndef CCPL_REGS_SVH
`define CCPL_REGS_SVH
// width of a frame address
`define CCPL_FA_W 8
// bits per configuration frame
`define CCPL_FRAME_BITS 16'h0040
// first frame address of a readback
`define CCPL_FA_FIRST 8'h00
// done-release option codes
`define CCPL_DONE_AT_END 2'h0
`define CCPL_DONE_ONE_LATER 2'h1
`endif

// [src/ccpl_pkg.sv]
package ccpl_pkg;
	// open-drain / two-way pin as two signals
	typedef struct packed {
		logic out;
		logic oe_n;
	} ccpl_pin_type;
	// readback sequencer states
	typedef enum logic [1:0] {
		ccpl_rb_idle = 2'b00,
		ccpl_rb_wait = 2'b01,
		ccpl_rb_shift = 2'b10
	} ccpl_rb_type;
	// configuration options
	typedef struct packed {
		logic keep_tristate;
		logic readback_en;
		logic [1:0] done_timing;
		logic [1:0] pins_timing;
	} ccpl_opt_type;
endpackage

// [dv/ccpl_host_model.sv]
`timescale 1ns/1ps
// host side: drives config clock, serves config memory bits
module ccpl_host_model (
	// clock
	input wire logic clk_i,
	// readback link
	input wire logic run_i,
	input wire logic [7:0] frame_i,
	input wire logic [15:0] bit_i,
	output logic config_clock_o,
	output logic rb_data_o
);
	// clock stands low outside readback, toggles each cycle inside
	// no initial value: run_i is low through reset, which forces a 0
	always @(negedge clk_i) begin
		config_clock_o <= run_i & ~config_clock_o;
	end
	// memory content: parity of the address, so a slip shows
	assign rb_data_o = ^{frame_i, bit_i[5:0]};
endmodule

// [dv/config_control_pin_logic_test.sv]
`timescale 1ns/1ps
`include "ccpl_regs.svh"
module config_control_pin_logic_test;
	import ccpl_pkg::*;
	logic clk = 0, rst = 1, rs_n = 1, rd_n = 1, dpin = 1, tdo = 0, scan = 0;
	logic busy = 0, ld = 0, err = 0, hp = 0, irq = 0, pd;
	logic config_clock, rbd, rdd, irq_n, ts, rs, srst, hiz, pu, rel, uio, st, act;
	ccpl_opt_type opt = '0;
	ccpl_pin_type done;
	logic [7:0] fr;
	logic [15:0] bn;
	logic [13:0] ea; // expected readback address: frame and bit
	int n_errors = 0, n_checks = 0;
	logic [15:0] lfsr = 16'h7729; // seed 30505
	ccpl_top i_ccpl_top (.clk_i(clk), .sys_rst_i(rst),
		.config_restart_n_i(rs_n), .rd_cfg_n_i(rd_n), .config_clock_i(config_clock),
		.done_pin_i(dpin), .scan_tdo_i(tdo), .scan_active_i(scan),
		.config_busy_i(busy), .config_loaded_i(ld), .init_error_i(err),
		.host_port_used_i(hp), .host_port_irq_i(irq), .opt_i(opt),
		.rb_data_i(rbd), .done_o(done), .rd_data_o(rdd), .cfg_irq_n_o(irq_n),
		.tristate_all_o(ts), .config_restart_o(rs), .scan_reset_o(srst),
		.pll_pins_hiz_o(hiz), .pll_pullup_o(pu), .pins_released_o(rel),
		.user_io_active_o(uio), .startup_o(st), .rb_frame_o(fr),
		.rb_bit_o(bn), .rb_active_o(act));
	ccpl_host_model i_ccpl_host_model (.clk_i(clk), .run_i(act),
		.frame_i(fr), .bit_i(bn), .config_clock_o(config_clock), .rb_data_o(rbd));
	// free-running system clock
	always #2 clk = ~clk;
	function automatic logic rnd();
		lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
		return lfsr[0];
	endfunction
	// expected memory bit: the host serves the parity of the address
	function automatic logic exp_bit(input logic [13:0] a);
		return ^a;
	endfunction
	// compare one bit, four-state exact
	task automatic chk(input logic got, input logic exp, input string m);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %0t %s", $time, m);
		end
	endtask
	// inputs move on falling edges only
	task automatic step(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic summarize();
		$display("errors %0d checks %0d", n_errors, n_checks);
		if (n_errors == 0 && n_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	initial begin
		// readback pin stays high through reset and restart
		step(5);
		chk(done.oe_n | ~hiz | ~pu, 1'b0, "reset levels");
		rst = 0;
		busy = 1;
		rs_n = 0;
		step(1);
		chk(rs & srst, 1'b1, "restart");
		rs_n = 1;
		rd_n = 0;
		step(1);
		chk(ts & hiz & pu & ~rs, 1'b1, "config tristate");
		rd_n = 1;
		// error path, then host port irq path
		for (int i = 0; i < 2; i++) begin
			hp = i[0];
			err = ~i[0];
			irq = i[0];
			step(1);
			chk(irq_n, 1'b0, "irq low");
		end
		irq = 0;
		step(1);
		chk(irq_n, 1'b1, "irq idle");
		scan = 1;
		repeat (20) begin
			tdo = rnd();
			step(1);
			chk(rdd, tdo, "scan data");
		end
		// scan unused from here: scan stays low
		scan = 0;
		busy = 0;
		ld = 1;
		dpin = 0;
		// done one cycle late, pins only after done is out
		opt.done_timing = `CCPL_DONE_ONE_LATER;
		opt.pins_timing = 2'h1;
		step(1);
		chk(done.oe_n, 1'b0, "done lag");
		step(1);
		chk(done.oe_n & ~rel, 1'b1, "done first");
		step(1);
		chk(done.out & rel & uio, 1'b1, "pins follow");
		chk(st | hiz | pu, 1'b0, "start held");
		dpin = 1;
		opt.keep_tristate = 1;
		opt.readback_en = 1;
		rd_n = 0;
		step(2);
		chk(st & ts & ~act, 1'b1, "tristate kept");
		rd_n = 1;
		opt.keep_tristate = 0;
		step(2);
		chk(ts, 1'b0, "tristate dropped");
		rd_n = 0;
		step(1);
		chk(act & (fr === `CCPL_FA_FIRST), 1'b1, "rb start");
		step(6);
		// restart mid readback, then done at load with pins alongside
		rs_n = 0;
		step(1);
		chk(act | done.oe_n, 1'b0, "restart abort");
		rs_n = 1;
		opt.done_timing = `CCPL_DONE_AT_END;
		opt.pins_timing = 2'h0;
		rd_n = 1;
		step(1);
		chk(done.out & done.oe_n & rel, 1'b1, "done at load");
		// second start must not reuse the cut readback's position
		rd_n = 0;
		step(1);
		chk(act & (fr === `CCPL_FA_FIRST), 1'b1, "rb restart");
		chk(bn === 16'h0000, 1'b1, "rb first bit");
		// bounded walk over all frames, address and data per cycle
		ea = 14'h0000;
		for (int k = 0; k < 40000 && act === 1'b1; k++) begin
			chk({fr, bn[5:0]} === ea, 1'b1, "bit order");
			pd = exp_bit(ea);
			step(1);
			chk(rdd, pd, "readback data");
			if (act === 1'b1 && {fr, bn[5:0]} !== ea) begin
				ea = ea + 14'h0001;
			end
		end
		chk(~act & (ea === 14'h3fff), 1'b1, "readback end");
		summarize();
	end
endmodule
